// *** rcoc_converter.v ***
// RC oscillation converter: reference and oscillation timers, mode and switch registers.
// Assumes a data-memory style register port on clk_sys and an async oscillator pin.
//
// Notes on behaviour
// R01 - Mode bit 0 picks overflow source timer
// R02 - Mode bit 1 enables converter mode
// R03 - Unused mode and switch bits read zero
// R04 - Mode bits 4-7 free user storage
// R05 - Two 16-bit timers: internal, external oscillator
// R06 - Count enable starts both timers together
// R07 - Selected overflow sets converter overflow flag
// R08 - Overflow stops both, clears count enable
// R09 - Low byte write only fills buffer
// R10 - High byte write loads full counter
// R11 - High byte read latches low byte
// R12 - Low byte read returns buffer; high first
// R13 - Timer bytes inaccessible while counting enabled
// R14 - Software should pick system clock sources
// R15 - Code 000 system clock, 001 divided four
// R16 - Switch code n closes switch pin n
// R17 - Codes above fifteen keep switches open
`timescale 1ns/10ps
`default_nettype none
`include "rcoc_defs.vh"

module rcoc_converter #(
    parameter SWITCHES = `RCOC_SWITCH_COUNT
) (
    input wire clk_sys,
    input wire reset_n,
    input wire [7:0] reg_addr,
    input wire reg_write,
    input wire reg_read,
    input wire [7:0] reg_wdata,
    output reg [7:0] reg_rdata,
    input wire rc_osc_in,
    output reg [SWITCHES-1:0] sensor_switch_pins,
    output reg converter_overflow_flag,
    output reg converter_count_enable
);
    reg overflow_source_select;
    reg converter_mode_enable;
    reg [3:0] user_nibble;
    reg [4:0] switch_select_field;
    reg [2:0] reference_clock_select;
    reg clk_spare;
    reg [1:0] div4_count;
    reg osc_sync1;
    reg osc_sync2;
    reg osc_prev;
    wire [SWITCHES-1:0] next_switches;
    reg [7:0] next_rdata;

    wire counting;
    wire tick_ref;
    wire tick_osc;
    wire hit_ta_lo;
    wire hit_ta_hi;
    wire hit_tb_lo;
    wire hit_tb_hi;
    wire timer_open;
    wire ovf_ref;
    wire ovf_osc;
    wire ovf_selected;
    wire [15:0] count_ref;
    wire [15:0] count_osc;
    wire [7:0] buf_ref;
    wire [7:0] buf_osc;

    assign counting = converter_count_enable && converter_mode_enable; // R02 R06
    assign tick_ref = counting && ((reference_clock_select == `RCOC_SEL_SYS) ||
        ((reference_clock_select == `RCOC_SEL_SYS_DIV4) &&
        (div4_count == `RCOC_DIV4_LAST))); // R15
    assign tick_osc = counting && osc_sync2 && !osc_prev; // R05
    assign timer_open = !converter_count_enable; // R13
    assign hit_ta_lo = timer_open && (reg_addr == `RCOC_ADDR_TA_LO);
    assign hit_ta_hi = timer_open && (reg_addr == `RCOC_ADDR_TA_HI);
    assign hit_tb_lo = timer_open && (reg_addr == `RCOC_ADDR_TB_LO);
    assign hit_tb_hi = timer_open && (reg_addr == `RCOC_ADDR_TB_HI);
    assign ovf_selected = overflow_source_select ? ovf_osc : ovf_ref; // R01

    rcoc_counter16 #(
        .WIDTH(16)
    ) u_ref_timer (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .count_tick(tick_ref),
        .write_lo(reg_write && hit_ta_lo),
        .write_hi(reg_write && hit_ta_hi),
        .read_hi(reg_read && hit_ta_hi),
        .wdata(reg_wdata),
        .count(count_ref),
        .lo_buffer(buf_ref),
        .overflow(ovf_ref)
    );

    rcoc_counter16 #(
        .WIDTH(16)
    ) u_osc_timer (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .count_tick(tick_osc),
        .write_lo(reg_write && hit_tb_lo),
        .write_hi(reg_write && hit_tb_hi),
        .read_hi(reg_read && hit_tb_hi),
        .wdata(reg_wdata),
        .count(count_osc),
        .lo_buffer(buf_osc),
        .overflow(ovf_osc)
    );

    // Oscillator pin synchroniser and edge memory
    always @(posedge clk_sys) begin
        if (!reset_n) begin
            osc_sync1 <= 1'b0;
            osc_sync2 <= 1'b0;
            osc_prev <= 1'b0;
        end else begin
            osc_sync1 <= rc_osc_in;
            osc_sync2 <= osc_sync1;
            osc_prev <= osc_sync2;
        end
    end

    // Divide-by-four prescaler, cleared while idle
    always @(posedge clk_sys) begin
        if (!reset_n || !counting) begin
            div4_count <= 2'h0;
        end else begin
            div4_count <= div4_count + 2'h1;
        end
    end

    // Control registers
    always @(posedge clk_sys) begin
        if (!reset_n) begin
            overflow_source_select <= 1'b0;
            converter_mode_enable <= 1'b0;
            user_nibble <= `RCOC_RST_USER_NIBBLE;
            switch_select_field <= `RCOC_RST_SWITCH_SEL;
            reference_clock_select <= `RCOC_SEL_SYS;
            clk_spare <= `RCOC_RST_CLK_SPARE;
            converter_count_enable <= 1'b0;
            converter_overflow_flag <= 1'b0;
        end else begin
            if (reg_write && reg_addr == `RCOC_ADDR_MODE) begin
                overflow_source_select <= reg_wdata[`RCOC_MODE_OVS_BIT]; // R01
                converter_mode_enable <= reg_wdata[`RCOC_MODE_EN_BIT]; // R02
                user_nibble <= reg_wdata[7:4]; // R04
            end
            if (reg_write && reg_addr == `RCOC_ADDR_SWITCH_SEL) begin
                switch_select_field <= reg_wdata[4:0];
            end
            if (ovf_selected) begin
                converter_count_enable <= 1'b0; // R08
            end else if (reg_write && reg_addr == `RCOC_ADDR_CLK_CTRL) begin
                converter_count_enable <= reg_wdata[`RCOC_CLK_CNT_EN_BIT]; // R06
            end
            if (reg_write && reg_addr == `RCOC_ADDR_CLK_CTRL) begin
                reference_clock_select <= reg_wdata[7:5]; // R15
                clk_spare <= reg_wdata[3];
            end
            if (ovf_selected) begin
                converter_overflow_flag <= 1'b1; // R07
            end else if (reg_write && reg_addr == `RCOC_ADDR_INT_CTRL2) begin
                converter_overflow_flag <= reg_wdata[`RCOC_INT_FLAG_BIT];
            end
        end
    end

    // One-of-sixteen switch decode
    genvar gi;
    generate
        for (gi = 0; gi < SWITCHES; gi = gi + 1) begin : g_switch
            localparam [4:0] CODE = gi;
            assign next_switches[gi] = (switch_select_field == CODE); // R16 R17
        end
    endgenerate

    always @(posedge clk_sys) begin
        if (!reset_n) begin
            sensor_switch_pins <= {SWITCHES{1'b0}};
        end else begin
            sensor_switch_pins <= next_switches;
        end
    end

    // Read data mux
    always @* begin
        next_rdata = 8'h00;
        case (reg_addr)
            `RCOC_ADDR_MODE: begin
                next_rdata = {user_nibble, 2'b00, converter_mode_enable,
                    overflow_source_select}; // R03 R04
            end
            `RCOC_ADDR_SWITCH_SEL: begin
                next_rdata = {3'b000, switch_select_field}; // R03
            end
            `RCOC_ADDR_CLK_CTRL: begin
                next_rdata = {reference_clock_select, converter_count_enable, clk_spare,
                    3'b000};
            end
            `RCOC_ADDR_INT_CTRL2: begin
                next_rdata = {3'b000, converter_overflow_flag, 4'h0};
            end
            `RCOC_ADDR_TA_LO: begin
                next_rdata = timer_open ? buf_ref : 8'h00; // R12 R13
            end
            `RCOC_ADDR_TA_HI: begin
                next_rdata = timer_open ? count_ref[15:8] : 8'h00; // R11 R13
            end
            `RCOC_ADDR_TB_LO: begin
                next_rdata = timer_open ? buf_osc : 8'h00; // R12 R13
            end
            `RCOC_ADDR_TB_HI: begin
                next_rdata = timer_open ? count_osc[15:8] : 8'h00; // R11 R13
            end
            default: begin
                next_rdata = 8'h00;
            end
        endcase
    end

    always @(posedge clk_sys) begin
        if (!reset_n) begin
            reg_rdata <= 8'h00;
        end else if (reg_read) begin
            reg_rdata <= next_rdata;
        end
    end
endmodule // rcoc_converter

`default_nettype wire

// *** rcoc_defs.vh ***
// Register addresses, field positions and reset values of the RC oscillation converter.
// Assumes inclusion by the converter modules only.
`ifndef RCOC_DEFS_VH
`define RCOC_DEFS_VH

`define RCOC_ADDR_SWITCH_SEL 8'h1A
`define RCOC_ADDR_INT_CTRL2 8'h1E
`define RCOC_ADDR_TA_LO 8'h20
`define RCOC_ADDR_TA_HI 8'h21
`define RCOC_ADDR_CLK_CTRL 8'h22
`define RCOC_ADDR_TB_LO 8'h23
`define RCOC_ADDR_TB_HI 8'h24
`define RCOC_ADDR_MODE 8'h25

`define RCOC_MODE_OVS_BIT 0
`define RCOC_MODE_EN_BIT 1
`define RCOC_CLK_CNT_EN_BIT 4
`define RCOC_INT_FLAG_BIT 4

`define RCOC_SEL_SYS 3'h0
`define RCOC_SEL_SYS_DIV4 3'h1
`define RCOC_DIV4_LAST 2'h3

`define RCOC_RST_SWITCH_SEL 5'h1F
`define RCOC_RST_USER_NIBBLE 4'h8
`define RCOC_RST_CLK_SPARE 1'b1
`define RCOC_SWITCH_COUNT 16

`endif

// *** rcoc_counter16.v ***
// One 16-bit up-counter with a buffered low byte for atomic byte access.
// Assumes the caller gates all strobes; strobes are single-cycle on clk_sys.
`timescale 1ns/10ps
`default_nettype none

module rcoc_counter16 #(
    parameter WIDTH = 16
) (
    input wire clk_sys,
    input wire reset_n,
    input wire count_tick,
    input wire write_lo,
    input wire write_hi,
    input wire read_hi,
    input wire [7:0] wdata,
    output reg [WIDTH-1:0] count,
    output reg [7:0] lo_buffer,
    output wire overflow
);
    assign overflow = count_tick && (count == {WIDTH{1'b1}});

    always @(posedge clk_sys) begin
        if (!reset_n) begin
            count <= {WIDTH{1'b0}};
            lo_buffer <= 8'h00;
        end else begin
            if (write_hi) begin
                count <= {wdata, lo_buffer}; // R10
            end else if (count_tick) begin
                count <= count + {{(WIDTH-1){1'b0}}, 1'b1}; // R05
            end
            if (write_lo) begin
                lo_buffer <= wdata; // R09
            end else if (read_hi) begin
                lo_buffer <= count[7:0]; // R11
            end
        end
    end
endmodule // rcoc_counter16

`default_nettype wire

// *** rcoc_converter_asserts.sv ***
// Port assertions for the RC oscillation converter.
// Assumes binding onto rcoc_converter.
`timescale 1ns/10ps
`default_nettype none
module rcoc_chk #(
    parameter SWITCHES = 16
) (
    input wire clk_sys,
    input wire reset_n,
    input wire [7:0] reg_addr,
    input wire reg_write,
    input wire reg_read,
    input wire [7:0] reg_wdata,
    input wire [7:0] reg_rdata,
    input wire [SWITCHES-1:0] sensor_switch_pins,
    input wire converter_overflow_flag,
    input wire converter_count_enable
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    sequence s_load;
        reg_write && reg_addr == 8'h20 && !converter_count_enable ##1
        reg_write && reg_addr == 8'h21 && !converter_count_enable ##1
        reg_read && reg_addr == 8'h21 && !converter_count_enable;
    endsequence
    a_sw_onehot: assert property ($onehot0(sensor_switch_pins))
        else $error("switch pins not one-hot");
    a_sw_decode: assert property (reg_write && reg_addr == 8'h1A |-> ##2 sensor_switch_pins ==
        ($past(reg_wdata[4], 2) ? 16'h0 : 16'h1 << $past(reg_wdata[3:0], 2)))
        else $error("switch decode wrong");
    a_sw_unused: assert property (reg_read && reg_addr == 8'h1A |=> reg_rdata[7:5] == 3'h0)
        else $error("switch unused bits set");
    a_busy_read: assert property (converter_count_enable && reg_read &&
        reg_addr inside {8'h20, 8'h21, 8'h23, 8'h24} |=> reg_rdata == 8'h00)
        else $error("timer read while counting");
    a_ovf_stop: assert property ($rose(converter_overflow_flag) |-> $fell(converter_count_enable))
        else $error("overflow without stop");
    a_start_count: assert property (reg_write && reg_addr == 8'h22 && reg_wdata[4] &&
        !converter_count_enable |=> converter_count_enable)
        else $error("count enable not set");
    a_load_read: assert property (s_load |=> reg_rdata == $past(reg_wdata, 2))
        else $error("loaded high byte wrong");
    a_flag_hold: assert property (converter_overflow_flag && !(reg_write && reg_addr == 8'h1E)
        |=> converter_overflow_flag)
        else $error("flag dropped");
endmodule // rcoc_chk
bind rcoc_converter rcoc_chk #(.SWITCHES(SWITCHES)) i_chk (.clk_sys(clk_sys), .reset_n(reset_n),
    .reg_addr(reg_addr), .reg_write(reg_write), .reg_read(reg_read), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .sensor_switch_pins(sensor_switch_pins),
    .converter_overflow_flag(converter_overflow_flag),
    .converter_count_enable(converter_count_enable));
`default_nettype wire

// *** rcoc_osc_model.sv ***
// Behavioural RC sensor oscillator.
// Assumes it oscillates only while a sensor switch is closed.
`timescale 1ns/10ps
`default_nettype none
module rcoc_osc_model #(
    parameter HALF_NS = 17
) (
    input wire [15:0] sensor_switch_pins,
    output logic rc_osc_in
);
    initial rc_osc_in = 1'b0;
    always begin
        #(HALF_NS);
        if (sensor_switch_pins != 16'h0) begin
            rc_osc_in = ~rc_osc_in;
        end
    end
endmodule // rcoc_osc_model
`default_nettype wire

// *** test_rcoc_converter.sv ***
// Self-checking bench for the RC oscillation converter.
// Assumes the bound checker and the oscillator model.
`timescale 1ns/10ps
`default_nettype none
module test_rcoc_converter;
    logic clk_sys = 0;
    logic reset_n = 0;
    logic [7:0] reg_addr = 0, reg_wdata = 0, d, a;
    logic reg_write = 0, reg_read = 0;
    logic [15:0] v, k;
    wire [7:0] reg_rdata;
    wire rc_osc_in, converter_overflow_flag, converter_count_enable;
    wire [15:0] sensor_switch_pins;
    int mismatches = 0, compares = 0, cycles = 0, n;
    rcoc_converter i_dut (.clk_sys(clk_sys), .reset_n(reset_n), .reg_addr(reg_addr),
        .reg_write(reg_write), .reg_read(reg_read), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .rc_osc_in(rc_osc_in), .sensor_switch_pins(sensor_switch_pins),
        .converter_overflow_flag(converter_overflow_flag),
        .converter_count_enable(converter_count_enable));
    rcoc_osc_model i_osc (.sensor_switch_pins(sensor_switch_pins), .rc_osc_in(rc_osc_in));
    always #5 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            mismatches++;
            stop_test();
        end
    end
    task stop_test;
        $display("mismatches=%0d compares=%0d", mismatches, compares);
        if (mismatches == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task chk(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    function logic [15:0] sw_exp(input logic [7:0] c);
        return c[4] ? 16'h0 : 16'h1 << c[3:0];
    endfunction
    task bus(input logic wr, input logic [7:0] ad, input logic [7:0] dt);
        reg_write = wr;
        reg_read = !wr;
        reg_addr = ad;
        reg_wdata = dt;
        @(posedge clk_sys);
        #1;
    endtask
    task rd(input logic [7:0] ad, input logic [7:0] e);
        bus(0, ad, 8'h00);
        chk({8'h00, reg_rdata}, {8'h00, e});
    endtask
    task idle(input int c);
        reg_write = 0;
        reg_read = 0;
        repeat (c) @(posedge clk_sys);
        #1;
    endtask
    task run(input logic [7:0] m, cc, ad, input logic [15:0] kk, input int lim);
        v = 16'hFFFF - kk;
        bus(1, 8'h25, m);
        bus(1, 8'h1E, 8'h00);
        bus(1, ad, v[7:0]);
        bus(1, ad + 8'h01, v[15:8]);
        bus(1, 8'h22, cc);
        reg_write = 0;
        n = 0;
        while (converter_overflow_flag !== 1'b1 && n < lim) begin
            @(posedge clk_sys);
            #1;
            n++;
        end
    endtask
    initial begin
        void'($urandom(92426));
        idle(2);
        reset_n = 1;
        rd(8'h25, 8'h80);
        rd(8'h22, 8'h08);
        rd(8'h1A, 8'h1F);
        for (int i = 0; i < 32; i++) begin
            d = {3'($urandom), 5'(i)};
            bus(1, 8'h1A, d);
            idle(2);
            chk(sensor_switch_pins, sw_exp(d));
            rd(8'h1A, d & 8'h1F);
            d = 8'($urandom);
            bus(1, 8'h25, d);
            rd(8'h25, d & 8'hF3);
            idle(1);
        end
        for (int t = 0; t < 2; t++) begin
            a = t ? 8'h23 : 8'h20;
            v = 16'($urandom);
            bus(1, a, v[7:0]);
            bus(1, a + 8'h01, v[15:8]);
            rd(a + 8'h01, v[15:8]);
            rd(a, v[7:0]);
            bus(1, a, ~v[7:0]);
            rd(a, ~v[7:0]);
            rd(a + 8'h01, v[15:8]);
            rd(a, v[7:0]);
            idle(1);
        end
        for (int i = 0; i < 8; i++) begin
            k = i ? 16'($urandom % (i < 4 ? 40 : 6)) : 16'h0;
            run({4'($urandom), 4'h2}, i < 4 ? 8'h10 : 8'h30, 8'h20, k, 2000);
            chk(16'(n), (k + 16'h1) * (i < 4 ? 16'h1 : 16'h4));
            chk(converter_count_enable, 16'h0);
            rd(8'h21, 8'h00);
            rd(8'h20, 8'h00);
        end
        bus(1, 8'h1A, 8'h05);
        bus(1, 8'h20, 8'hFD);
        run(8'h03, 8'h10, 8'h23, 16'h3, 2000);
        chk(converter_overflow_flag, 16'h1);
        rd(8'h24, 8'h00);
        rd(8'h23, 8'h00);
        rd(8'h21, 8'h00);
        bus(0, 8'h20, 8'h00);
        chk({15'h0, reg_rdata != 8'h00}, 16'h1);
        run(8'h00, 8'h10, 8'h20, 16'h0, 20);
        chk(converter_overflow_flag, 16'h0);
        bus(1, 8'h21, 8'h12);
        rd(8'h21, 8'h00);
        bus(1, 8'h22, 8'h00);
        rd(8'h21, 8'hFF);
        run(8'h02, 8'h50, 8'h20, 16'h0, 20);
        chk(converter_overflow_flag, 16'h0);
        idle(1);
        stop_test();
    end
endmodule // test_rcoc_converter
`default_nettype wire
